// ---- design/fsi_consts.svh ----
`ifndef FSI_CONSTS_SVH
`define FSI_CONSTS_SVH

// slave state request codes on the command port
`define FSI_REQ_INIT        4'h1
`define FSI_REQ_PREOP       4'h2
`define FSI_REQ_SAFEOP      4'h4
`define FSI_REQ_OP          4'h8

// indicator timing, ms and derived cycles at 20 MHz
`define FSI_CLK_HZ          20000000
`define FSI_FLASH_MS        200
`define FSI_FLASH_CYC       ((`FSI_CLK_HZ / 1000) * `FSI_FLASH_MS)
`define FSI_GAP_MS          1000
`define FSI_GAP_CYC         ((`FSI_CLK_HZ / 1000) * `FSI_GAP_MS)

// fifo geometry
`define FSI_FIFO_DEPTH      16
`define FSI_DATA_W          32

`endif

// ---- design/fsi_fifo.sv ----
`timescale 1ns/100ps
module fsi_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;
    logic             push;
    logic             pop;

    assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr != rd_ptr;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr[AW-1:0]];

    always_comb begin
        next_wr_ptr = wr_ptr + (AW+1)'(push);
        next_rd_ptr = rd_ptr + (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    a_fifo_no_overflow: assert property (@(posedge clk) disable iff (!resetn)
        (wr_ptr - rd_ptr) <= (AW+1)'(DEPTH)) else $error("fifo overfilled");
endmodule // fsi_fifo

// ---- design/fsi_pkg.sv ----
package fsi_pkg;
    typedef enum logic [3:0] {
        FSI_INIT   = 4'h1,
        FSI_PREOP  = 4'h2,
        FSI_SAFEOP = 4'h4,
        FSI_OP     = 4'h8
    } fsi_state_type;

    typedef enum logic [1:0] {
        FSI_LED_OFF   = 2'h0,
        FSI_LED_GREEN = 2'h1,
        FSI_LED_RED   = 2'h2
    } fsi_led_type;
endpackage

// ---- design/fsi_slave.sv ----
// Function
// R1 - exactly four states: init, preop, safeop, op; legal moves only
// R2 - start in init after reset; operational is the normal end
// R3 - master commands every state change; slave never moves itself
// R4 - traffic gated: init none, preop service, safeop adds tx, op adds rx
// R5 - slave-to-master data read-only; master-to-slave data writable
// R6 - measurements go slave-to-master, set points master-to-slave
// R7 - service messages handled on request, no timing guarantee
// R8 - master avoids service writes to process-mapped variables
// R9 - service writes only to read/write flagged, unmapped variables
// R10 - either port may be upstream; other port forwards onward
// R11 - run light: off init, blink preop, single flash safeop, on op, red fatal
// R12 - error light: blink config, one flash, two flashes, steady red
// R13 - link light: off no link, green link, blinking with activity
// R14 - flash and blink periods are parameters
// R15 - illegal state request rejected, state kept, config error shown
`timescale 1ns/100ps
`include "fsi_consts.svh"
module fsi_slave #(
    parameter int FLASH_CYC = `FSI_FLASH_CYC,
    parameter int GAP_CYC   = `FSI_GAP_CYC,
    parameter int WIDTH     = `FSI_DATA_W,
    parameter int DEPTH     = `FSI_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // state requests from the master
    input  wire logic             req_valid,
    input  wire logic [3:0]       req_state,
    input  wire logic             cfg_ok,
    output fsi_pkg::fsi_state_type cur_state,
    // service channel write
    input  wire logic             svc_valid,
    input  wire logic             svc_write,
    input  wire logic             svc_var_rw,
    input  wire logic             svc_var_mapped,
    output logic                  svc_accept,
    output logic                  svc_refuse,
    // measurements out, slave to master
    input  wire logic             meas_valid,
    output logic                  meas_ready,
    input  wire logic [WIDTH-1:0] meas_data,
    output logic                  tx_valid,
    input  wire logic             tx_ready,
    output logic      [WIDTH-1:0] tx_data,
    // set points in, master to slave
    input  wire logic             rx_valid,
    input  wire logic [WIDTH-1:0] rx_data,
    output logic                  setp_valid,
    output logic      [WIDTH-1:0] setp_data,
    // faults and port status, asynchronous pins
    input  wire logic             fatal_err,
    input  wire logic             wdog_timeout,
    input  wire logic             app_fail,
    input  wire logic [1:0]       port_link,
    input  wire logic [1:0]       port_act,
    output logic      [1:0]       upstream_port,
    // indicators
    output fsi_pkg::fsi_led_type  run_led,
    output fsi_pkg::fsi_led_type  err_led,
    output logic      [1:0]       link_led
);
    // pin synchronisers
    logic [6:0] sync1;
    logic [6:0] sync2;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {fatal_err, wdog_timeout, app_fail, port_link, port_act};
            sync2 <= sync1;
        end
    end
    logic       s_fatal;
    logic       s_wdog;
    logic       s_app;
    logic [1:0] s_link;
    logic [1:0] s_act;
    assign {s_fatal, s_wdog, s_app, s_link, s_act} = sync2;

    function automatic logic legal_move(input logic [3:0] from, input logic [3:0] to);
        case (to)
            `FSI_REQ_INIT:   legal_move = 1'b1;
            `FSI_REQ_PREOP:  legal_move = from != `FSI_REQ_OP;
            `FSI_REQ_SAFEOP: legal_move = from != `FSI_REQ_INIT;
            `FSI_REQ_OP:     legal_move = from == `FSI_REQ_SAFEOP || from == `FSI_REQ_OP;
            default:         legal_move = 1'b0;
        endcase
    endfunction

    // state machine, moved only by requests
    fsi_pkg::fsi_state_type next_state;
    logic                   cfg_err;
    logic                   next_cfg_err;
    always_comb begin
        next_state   = cur_state;
        next_cfg_err = cfg_err;
        if (req_valid) begin // [R3]
            if (legal_move(cur_state, req_state) && (cfg_ok || req_state == `FSI_REQ_INIT)) begin
                next_state   = fsi_pkg::fsi_state_type'(req_state); // [R1]
                next_cfg_err = 1'b0;
            end else begin
                next_cfg_err = 1'b1; // [R15]
            end
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur_state <= fsi_pkg::FSI_INIT; // [R2]
            cfg_err   <= 1'b0;
        end else begin
            cur_state <= next_state;
            cfg_err   <= next_cfg_err;
        end
    end

    // traffic gates
    logic svc_open;
    logic tx_open;
    logic rx_open;
    assign svc_open = cur_state != fsi_pkg::FSI_INIT; // [R4]
    assign tx_open  = cur_state == fsi_pkg::FSI_SAFEOP || cur_state == fsi_pkg::FSI_OP; // [R4]
    assign rx_open  = cur_state == fsi_pkg::FSI_OP; // [R4]

    // service writes: read/write and not process mapped
    logic next_svc_accept;
    logic next_svc_refuse;
    always_comb begin
        next_svc_accept = 1'b0;
        next_svc_refuse = 1'b0;
        if (svc_valid && svc_open) begin // [R7]
            if (!svc_write || (svc_var_rw && !svc_var_mapped)) begin // [R9]
                next_svc_accept = 1'b1;
            end else begin
                next_svc_refuse = 1'b1;
            end
        end else if (svc_valid) begin
            next_svc_refuse = 1'b1;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            svc_accept <= 1'b0;
            svc_refuse <= 1'b0;
        end else begin
            svc_accept <= next_svc_accept;
            svc_refuse <= next_svc_refuse;
        end
    end

    // measurements flow through the fifo, read-only to the master
    logic             f_valid;
    logic [WIDTH-1:0] f_data;
    fsi_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_tx_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .in_valid  (meas_valid),
        .in_ready  (meas_ready),
        .in_data   (meas_data),
        .out_valid (f_valid),
        .out_ready (tx_ready && tx_open),
        .out_data  (f_data)
    ); // [R6]
    assign tx_valid = f_valid && tx_open; // [R5]
    assign tx_data  = f_data;

    // set points written by the master only in operational
    logic             next_setp_valid;
    logic [WIDTH-1:0] next_setp_data;
    always_comb begin
        next_setp_valid = rx_valid && rx_open; // [R5]
        next_setp_data  = next_setp_valid ? rx_data : setp_data; // [R6]
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            setp_valid <= 1'b0;
            setp_data  <= '0;
        end else begin
            setp_valid <= next_setp_valid;
            setp_data  <= next_setp_data;
        end
    end

    // upstream is the first port to show a link, port 0 on a tie; kept while its link holds
    logic [1:0] next_up;
    always_comb begin
        next_up = upstream_port;
        if (upstream_port == 2'h0 || !(|(upstream_port & s_link))) begin // [R10]
            next_up = s_link[0] ? 2'h1 : (s_link[1] ? 2'h2 : 2'h0);
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) upstream_port <= 2'h0;
        else         upstream_port <= next_up;
    end

    // flash timebase: 8 slots per frame, one slot per flash period
    logic [31:0] tick_cnt;
    logic [31:0] next_tick_cnt;
    logic [2:0]  slot;
    logic [2:0]  next_slot;
    logic [31:0] gap_cnt;
    logic [31:0] next_gap_cnt;
    logic        in_gap;
    always_comb begin
        next_tick_cnt = tick_cnt + 32'h1;
        next_slot     = slot;
        next_gap_cnt  = gap_cnt;
        if (in_gap) begin
            next_tick_cnt = 32'h0;
            next_gap_cnt  = gap_cnt + 32'h1;
            if (gap_cnt >= 32'(GAP_CYC)) next_gap_cnt = 32'h0;
        end else if (tick_cnt >= 32'(FLASH_CYC - 1)) begin // [R14]
            next_tick_cnt = 32'h0;
            next_slot     = slot + 3'h1;
            if (slot == 3'h7) next_gap_cnt = 32'h1;
        end
    end
    assign in_gap = gap_cnt != 32'h0;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tick_cnt <= 32'h0;
            slot     <= 3'h0;
            gap_cnt  <= 32'h0;
        end else begin
            tick_cnt <= next_tick_cnt;
            slot     <= next_slot;
            gap_cnt  <= next_gap_cnt;
        end
    end
    logic blink;
    logic flash1;
    logic flash2;
    assign blink  = !slot[0] && !in_gap;
    assign flash1 = slot == 3'h0 && !in_gap;
    assign flash2 = (slot == 3'h0 || slot == 3'h2) && !in_gap;

    // unsolicited change: state dropped without a request
    logic unsol;
    logic next_unsol;
    always_comb begin
        next_unsol = unsol;
        if (cur_state != next_state && !req_valid) next_unsol = 1'b1;
        if (req_valid) next_unsol = 1'b0;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) unsol <= 1'b0;
        else         unsol <= next_unsol;
    end

    // indicator drive, registered
    fsi_pkg::fsi_led_type next_run;
    fsi_pkg::fsi_led_type next_err;
    logic [1:0]           next_link;
    always_comb begin
        next_run = fsi_pkg::FSI_LED_OFF;
        if (s_fatal) next_run = fsi_pkg::FSI_LED_RED; // [R11]
        else case (cur_state)
            fsi_pkg::FSI_OP:     next_run = fsi_pkg::FSI_LED_GREEN;
            fsi_pkg::FSI_PREOP:  next_run = blink ? fsi_pkg::FSI_LED_GREEN : fsi_pkg::FSI_LED_OFF;
            fsi_pkg::FSI_SAFEOP: next_run = flash1 ? fsi_pkg::FSI_LED_GREEN : fsi_pkg::FSI_LED_OFF;
            default:             next_run = fsi_pkg::FSI_LED_OFF;
        endcase
        next_err = fsi_pkg::FSI_LED_OFF;
        if (s_app) next_err = fsi_pkg::FSI_LED_RED; // [R12]
        else if (s_wdog) next_err = flash2 ? fsi_pkg::FSI_LED_RED : fsi_pkg::FSI_LED_OFF;
        else if (unsol) next_err = flash1 ? fsi_pkg::FSI_LED_RED : fsi_pkg::FSI_LED_OFF;
        else if (cfg_err) next_err = blink ? fsi_pkg::FSI_LED_RED : fsi_pkg::FSI_LED_OFF; // [R15]
        for (int i = 0; i < 2; i++) begin
            next_link[i] = s_link[i] && (!s_act[i] || blink); // [R13]
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            run_led  <= fsi_pkg::FSI_LED_OFF;
            err_led  <= fsi_pkg::FSI_LED_OFF;
            link_led <= 2'h0;
        end else begin
            run_led  <= next_run;
            err_led  <= next_err;
            link_led <= next_link;
        end
    end

    // checks
    a_state_hold: assert property (@(posedge clk) disable iff (!resetn)
        !req_valid |=> $stable(cur_state)) else $error("state moved unasked"); // [R3]
    a_rx_gated: assert property (@(posedge clk) disable iff (!resetn)
        setp_valid |-> $past(cur_state) == fsi_pkg::FSI_OP) else $error("rx outside op"); // [R4]
    a_tx_gated: assert property (@(posedge clk) disable iff (!resetn)
        tx_valid |-> cur_state == fsi_pkg::FSI_SAFEOP || cur_state == fsi_pkg::FSI_OP)
        else $error("tx outside safeop/op"); // [R4]
    a_skip_rejected: assert property (@(posedge clk) disable iff (!resetn)
        req_valid && cur_state == fsi_pkg::FSI_INIT && req_state == `FSI_REQ_OP
        |=> cur_state == fsi_pkg::FSI_INIT && cfg_err) else $error("skip accepted"); // [R15]
    a_svc_refuse_ro: assert property (@(posedge clk) disable iff (!resetn)
        svc_valid && svc_write && !svc_var_rw |=> svc_refuse && !svc_accept)
        else $error("ro write accepted"); // [R9]
    a_run_op_green: assert property (@(posedge clk) disable iff (!resetn)
        cur_state == fsi_pkg::FSI_OP && !s_fatal |=> run_led == fsi_pkg::FSI_LED_GREEN)
        else $error("run light not green"); // [R11]
    a_err_app_red: assert property (@(posedge clk) disable iff (!resetn)
        s_app |=> err_led == fsi_pkg::FSI_LED_RED) else $error("err light not red"); // [R12]
    a_link_off: assert property (@(posedge clk) disable iff (!resetn)
        !s_link[0] |=> !link_led[0]) else $error("link light on without link"); // [R13]
    a_init_after_reset: assert property (@(posedge clk)
        $rose(resetn) |-> cur_state == fsi_pkg::FSI_INIT) else $error("not init"); // [R2]
endmodule // fsi_slave

// ---- tb/fsi_master_model.sv ----
`timescale 1ns/100ps
module fsi_master_model (
    // clock and stall control
    input  wire logic        clk,
    input  wire logic        stall,
    // state requests
    output logic             req_valid,
    output logic [3:0]       req_state,
    output logic             cfg_ok,
    // service channel
    output logic             svc_valid,
    output logic             svc_write,
    output logic             svc_var_rw,
    output logic             svc_var_mapped,
    // process data
    output logic             tx_ready,
    output logic             rx_valid,
    output logic [31:0]      rx_data
);
    logic [1:0] stall_cnt = 2'h0;

    initial begin
        {req_valid, svc_valid, svc_write, svc_var_rw, svc_var_mapped, rx_valid} = 6'h00;
        req_state = 4'h0;
        cfg_ok    = 1'b1;
        rx_data   = 32'h0;
    end

    // drops ready one cycle in three while stalling
    always @(negedge clk) begin
        stall_cnt <= (stall_cnt == 2'h2) ? 2'h0 : stall_cnt + 2'h1;
        tx_ready  <= !(stall && stall_cnt == 2'h2);
    end

    // state changes only when the bench commands one
    task automatic request(input logic [3:0] st, input logic ok);
        @(negedge clk);
        req_valid = 1'b1;
        req_state = st;
        cfg_ok    = ok;
        @(negedge clk);
        req_valid = 1'b0;
        req_state = ~st;
    endtask

    // mapped writes are sent only when a refusal is checked
    task automatic service(input logic wr, input logic rw, input logic mp);
        @(negedge clk);
        {svc_valid, svc_write, svc_var_rw, svc_var_mapped} = {1'b1, wr, rw, mp};
        @(negedge clk);
        {svc_valid, svc_write, svc_var_rw, svc_var_mapped} = {1'b0, ~wr, ~rw, ~mp};
    endtask

    task automatic set_point(input logic [31:0] d);
        @(negedge clk);
        rx_valid = 1'b1;
        rx_data  = d;
        @(negedge clk);
        rx_valid = 1'b0;
        rx_data  = ~d;
    endtask
endmodule // fsi_master_model

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
module testbench;
    localparam int FL    = 4;
    localparam int GP    = 10;
    localparam int FRAME = 8 * FL + GP;
    logic                   clk = 1'b0, resetn = 1'b0, stall = 1'b0;
    logic                   req_valid, cfg_ok, svc_valid, svc_write, svc_var_rw, svc_var_mapped;
    logic [3:0]             req_state;
    fsi_pkg::fsi_state_type cur_state;
    logic                   svc_accept, svc_refuse, meas_ready, tx_valid, tx_ready, rx_valid;
    logic                   meas_valid = 1'b0, setp_valid;
    logic [31:0]            meas_data = 32'h0, tx_data, rx_data, setp_data;
    logic                   fatal_err = 1'b0, wdog_timeout = 1'b0, app_fail = 1'b0;
    logic [1:0]             port_link = 2'h0, port_act = 2'h0, upstream_port, link_led;
    fsi_pkg::fsi_led_type   run_led, err_led;
    int                     n_mismatch = 0, checks_done = 0;

    fsi_slave #(.FLASH_CYC(FL), .GAP_CYC(GP)) dut_u (.clk(clk), .resetn(resetn),
        .req_valid(req_valid), .req_state(req_state), .cfg_ok(cfg_ok), .cur_state(cur_state),
        .svc_valid(svc_valid), .svc_write(svc_write), .svc_var_rw(svc_var_rw),
        .svc_var_mapped(svc_var_mapped), .svc_accept(svc_accept), .svc_refuse(svc_refuse),
        .meas_valid(meas_valid), .meas_ready(meas_ready), .meas_data(meas_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
        .rx_data(rx_data), .setp_valid(setp_valid), .setp_data(setp_data),
        .fatal_err(fatal_err), .wdog_timeout(wdog_timeout), .app_fail(app_fail),
        .port_link(port_link), .port_act(port_act), .upstream_port(upstream_port),
        .run_led(run_led), .err_led(err_led), .link_led(link_led));

    fsi_master_model mm_u (.clk(clk), .stall(stall), .req_valid(req_valid),
        .req_state(req_state), .cfg_ok(cfg_ok), .svc_valid(svc_valid), .svc_write(svc_write),
        .svc_var_rw(svc_var_rw), .svc_var_mapped(svc_var_mapped), .tx_ready(tx_ready),
        .rx_valid(rx_valid), .rx_data(rx_data));

    always #25 clk = ~clk;

    task automatic check_vec(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask

    task automatic check_state(input fsi_pkg::fsi_state_type exp, input string m);
        checks_done++;
        if (cur_state !== exp) begin
            n_mismatch++;
            $display("FAIL %0t %s state %0h", $time, m, cur_state);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // cycles showing one colour, off included, over one indicator frame
    task automatic led_count(input logic err, input fsi_pkg::fsi_led_type col, output int n);
        n = 0;
        repeat (FRAME) begin
            @(negedge clk);
            if ((err ? err_led : run_led) === col) n++;
        end
    endtask

    task automatic svc_check(input logic wr, rw, mp, input logic [1:0] exp, input string m);
        logic [1:0] seen;
        seen = 2'h0;
        mm_u.service(wr, rw, mp);
        repeat (3) begin
            seen = seen | {svc_accept, svc_refuse};
            @(negedge clk);
        end
        check_vec(32'(seen), 32'(exp), m);
    endtask

    task automatic t_start;
        int n;
        check_state(fsi_pkg::FSI_INIT, "reset state");
        check_vec(32'(meas_ready), 32'h1, "ready at reset");
        check_vec(32'(link_led), 32'h0, "link off");
        svc_check(1'b0, 1'b1, 1'b0, 2'h1, "svc in init");
        mm_u.request(fsi_pkg::FSI_OP, 1'b1);
        check_state(fsi_pkg::FSI_INIT, "init to op");
        led_count(1'b1, fsi_pkg::FSI_LED_RED, n);
        check_vec(n, 4 * FL, "cfg blink");
        led_count(1'b0, fsi_pkg::FSI_LED_OFF, n);
        check_vec(n, FRAME, "run off init");
        $display("test start done");
    endtask

    task automatic t_preop;
        int n;
        mm_u.request(fsi_pkg::FSI_PREOP, 1'b1);
        check_state(fsi_pkg::FSI_PREOP, "to preop");
        led_count(1'b1, fsi_pkg::FSI_LED_RED, n);
        check_vec(n, 0, "cfg cleared");
        led_count(1'b0, fsi_pkg::FSI_LED_GREEN, n);
        check_vec(n, 4 * FL, "run blink");
        mm_u.request(fsi_pkg::FSI_OP, 1'b1);
        check_state(fsi_pkg::FSI_PREOP, "preop to op");
        mm_u.request(fsi_pkg::FSI_SAFEOP, 1'b0);
        check_state(fsi_pkg::FSI_PREOP, "bad cfg");
        svc_check(1'b0, 1'b0, 1'b0, 2'h2, "read");
        svc_check(1'b1, 1'b1, 1'b0, 2'h2, "rw write");
        svc_check(1'b1, 1'b0, 1'b0, 2'h1, "ro write");
        svc_check(1'b1, 1'b1, 1'b1, 2'h1, "mapped write");
        $display("test preop done");
    endtask

    task automatic t_fifo;
        int n;
        int k;
        n = 0;
        k = 0;
        for (int i = 0; i < 20; i++) begin
            @(negedge clk);
            meas_valid = 1'b1;
            meas_data  = 32'hA000 + 32'(i);
            #1;
            if (meas_ready !== 1'b1) break;
            n++;
            check_vec(32'(tx_valid), 32'h0, "tx in preop");
        end
        @(negedge clk);
        meas_valid = 1'b0;
        meas_data  = ~meas_data;
        check_vec(n, 16, "fill depth");
        stall = 1'b1;
        mm_u.request(fsi_pkg::FSI_SAFEOP, 1'b1);
        check_state(fsi_pkg::FSI_SAFEOP, "to safeop");
        for (int c = 0; c < 100 && k < n; c++) begin
            #1;
            if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
                check_vec(tx_data, 32'hA000 + 32'(k), "tx order");
                k++;
            end
            @(negedge clk);
        end
        check_vec(k, n, "drained");
        if (k != n) report_and_stop();
        @(negedge clk);
        check_vec(32'(tx_valid), 32'h0, "empty");
        stall = 1'b0;
        $display("test fifo done");
    endtask

    task automatic rx_check(input logic exp, input string m);
        logic seen;
        seen = 1'b0;
        mm_u.set_point(32'h5A3C_0F96);
        repeat (3) begin
            seen = seen | setp_valid;
            @(negedge clk);
        end
        check_vec(32'(seen), 32'(exp), m);
        if (exp) check_vec(setp_data, 32'h5A3C_0F96, "setp data");
    endtask

    task automatic t_run;
        int n;
        led_count(1'b0, fsi_pkg::FSI_LED_GREEN, n);
        check_vec(n, FL, "single flash");
        rx_check(1'b0, "rx in safeop");
        mm_u.request(fsi_pkg::FSI_OP, 1'b1);
        check_state(fsi_pkg::FSI_OP, "to op");
        led_count(1'b0, fsi_pkg::FSI_LED_GREEN, n);
        check_vec(n, FRAME, "run steady");
        rx_check(1'b1, "rx in op");
        $display("test run done");
    endtask

    task automatic t_faults;
        int n;
        int on;
        @(negedge clk);
        wdog_timeout = 1'b1;
        repeat (4) @(negedge clk);
        led_count(1'b1, fsi_pkg::FSI_LED_RED, n);
        check_vec(n, 2 * FL, "two flashes");
        app_fail = 1'b1;
        repeat (4) @(negedge clk);
        led_count(1'b1, fsi_pkg::FSI_LED_RED, n);
        check_vec(n, FRAME, "err steady");
        {wdog_timeout, app_fail, fatal_err} = 3'h1;
        repeat (4) @(negedge clk);
        led_count(1'b0, fsi_pkg::FSI_LED_RED, n);
        check_vec(n, FRAME, "fatal red");
        check_state(fsi_pkg::FSI_OP, "no own move");
        fatal_err = 1'b0;
        port_link = 2'h2;
        repeat (4) @(negedge clk);
        check_vec(32'(upstream_port), 32'h2, "upstream");
        check_vec(32'(link_led), 32'h2, "link green");
        port_link = 2'h3;
        port_act  = 2'h2;
        repeat (4) @(negedge clk);
        check_vec(32'(upstream_port), 32'h2, "sticky");
        on = 0;
        repeat (FRAME) begin
            @(negedge clk);
            if (link_led === 2'h3) on++;
        end
        check_vec(on, 4 * FL, "link blink");
        check_vec(32'(link_led[0]), 32'h1, "port0 steady");
        $display("test faults done");
    endtask

    initial begin
        #500000;
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        t_start();
        t_preop();
        t_fifo();
        t_run();
        t_faults();
        @(negedge clk);
        resetn = 1'b0;
        @(negedge clk);
        resetn = 1'b1;
        check_state(fsi_pkg::FSI_INIT, "second reset");
        report_and_stop();
    end
endmodule // testbench
